// [pkg/pdcs_map.vh]
`ifndef PDCS_MAP_VH
`define PDCS_MAP_VH
`define PDCS_ADDR_PHASE_CTRL 12'h000
`define PDCS_ADDR_REF_CTRL 12'h004
`define PDCS_ADDR_STATUS 12'h008
`define PDCS_ADDR_SEC_SEL 12'h00C
`define PDCS_ADDR_PRI_SEL 12'h010
`define PDCS_ADDR_PHASE_READ 12'h014
`define PDCS_ADDR_SET_DIV 12'h018
`define PDCS_ADDR_SET_FB 12'h01C
`define PDCS_PC_TARGET_LSB 0
`define PDCS_PC_DIR_BIT 2
`define PDCS_PC_TOGGLE_BIT 3
`define PDCS_PC_ORIGIN_BIT 4
`define PDCS_PC_FB_LSB 5
`define PDCS_RC_SEL_BIT 0
`define PDCS_RC_RESET_BIT 1
`define PDCS_RC_FULLRESET_BIT 2
`define PDCS_ST_LOCK_BIT 0
`define PDCS_ST_ORIGIN_BIT 1
`define PDCS_ST_REFSEL_BIT 2
`define PDCS_ST_MRST_BIT 3
`define PDCS_PC_RESET 32'h00000000
`define PDCS_SEC_RESET 32'h00000000
`define PDCS_PRI_RESET 32'h00000000
`define PDCS_DIV_RESET 8'h01
`define PDCS_FB_RESET 8'h01
`define PDCS_PHASE_RESET 8'h00
`define PDCS_LOCK_TIME_NS 50000
`define PDCS_CLK_PERIOD_NS 4
`define PDCS_LOCK_CYCLES ((`PDCS_LOCK_TIME_NS + `PDCS_CLK_PERIOD_NS - 1) / `PDCS_CLK_PERIOD_NS)
`endif

// [rtl/pdcs_settings_regs.v]
`include "pdcs_map.vh"
module pdcs_settings_regs
(
  input wire pclk,
  input wire presetn,
  input wire settings_bus_strobe,
  input wire settings_bus_write_enable,
  input wire [4:0] settings_bus_index,
  input wire [7:0] settings_bus_write_data,
  output reg [7:0] settings_bus_read_data,
  output reg settings_bus_acknowledge,
  output wire settings_changed,
  output wire [7:0] divider_value,
  output wire [7:0] feedback_divider
);
  reg [7:0] mem [0:31];
  integer i;
  wire write_now;
  assign write_now = settings_bus_strobe && settings_bus_write_enable && !settings_bus_acknowledge;
  assign settings_changed = write_now;
  assign divider_value = mem[0];
  assign feedback_divider = mem[1];
  // One-cycle acknowledge per strobe; strobe must drop after ack before the next access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settings_bus_acknowledge <= 1'b0;
      settings_bus_read_data <= 8'h00;
      for (i = 0; i < 32; i = i + 1)
        mem[i] <= 8'h00;
      // Dividers wake up at their configured values, not zero
      mem[0] <= `PDCS_DIV_RESET;
      mem[1] <= `PDCS_FB_RESET;
    end
    else
    begin
      settings_bus_acknowledge <= settings_bus_strobe && !settings_bus_acknowledge;
      if (write_now)
        mem[settings_bus_index] <= settings_bus_write_data; // RULE7 RULE14
      if (settings_bus_strobe && !settings_bus_acknowledge)
        settings_bus_read_data <= mem[settings_bus_index];
    end
  end
endmodule // pdcs_settings_regs

// [rtl/pdcs_sync2.v]
module pdcs_sync2
#(
  parameter W = 1
)
(
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage1;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // pdcs_sync2

// [rtl/pdcs_top.v]
// Operation
// RULE1 - A two-bit target selector picks which output clock the phase step acts on.
// RULE2 - A direction bit decides whether each step advances or retards the phase.
// RULE3 - Each toggle of the step input moves the selected phase by exactly one increment.
// RULE4 - Phase offsets start from configured values and may be changed at run time.
// RULE5 - A step on the feedback output drops lock until the relock time has elapsed.
// RULE6 - A run-time selector switches the reference between two reference clocks.
// RULE7 - Loop settings including dividers may be rewritten at run time over a bus port.
// RULE8 - After a settings rewrite lock drops and returns only after the relock time.
// RULE9 - Eight secondary nets are each driven by an 8:1 mux, input 0 from the clock pin.
// RULE10 - Primary muxes are 27:1 on large variants and 17:1 on small ones.
// RULE11 - An active-high lock indication is high only while the loop is locked.
// RULE12 - Two active-high loop resets, one of which also clears the feedback divider.
// RULE13 - An output shows whether phase control comes from ports or the bus.
// RULE14 - The settings bus uses a 5-bit index, 8-bit data, strobe, write enable, acknowledge.
// RULE15 - User logic waits for lock before relying on adjusted output clocks.
//
// The APB register port and the register offsets were decided locally.
`include "pdcs_map.vh"
module pdcs_top
#(
  parameter LOCK_CYCLES = `PDCS_LOCK_CYCLES,
  parameter LARGE_VARIANT = 1
)
(
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [1:0] output_phase_target_select,
  input wire phase_shift_direction,
  input wire phase_increment_toggle,
  input wire reference_source_switch,
  input wire loop_reset,
  input wire loop_full_clear_with_feedback_divider,
  input wire embedded_function_wrapper,
  input wire settings_bus_strobe,
  input wire settings_bus_write_enable,
  input wire [4:0] settings_bus_index,
  input wire [7:0] settings_bus_write_data,
  output wire [7:0] settings_bus_read_data,
  output wire settings_bus_acknowledge,
  input wire [1:0] reference_clock_present,
  input wire [7:0] secondary_pin_input,
  input wire [55:0] secondary_routing_input,
  input wire [26:0] primary_mux_input,
  output reg [7:0] secondary_net,
  output reg primary_net,
  output reg [7:0] phase_offset_out,
  output reg loop_lock,
  output reg phase_control_origin,
  output reg active_reference,
  output reg [7:0] feedback_divider_out
);
  localparam ST_LOCKING = 1'b0;
  localparam ST_LOCKED = 1'b1;
  wire [1:0] s_sel;
  wire s_dir;
  wire s_tog;
  wire s_ref;
  wire s_rst;
  wire s_mrst;
  wire s_wrap;
  wire [1:0] s_refok;
  wire [7:0] s_pin;
  wire [55:0] s_rout;
  wire [26:0] s_pri;
  wire settings_changed;
  wire [7:0] div_value;
  wire [7:0] fb_value;
  reg [31:0] phase_ctrl;
  reg [31:0] sec_sel;
  reg [31:0] pri_sel;
  reg [7:0] phase_offset [0:3];
  reg tog_prev;
  reg bus_tog_prev;
  reg state;
  reg [31:0] lock_count;
  reg [1:0] fb_output;
  reg ref_sel;
  reg reg_reset;
  reg reg_full_reset;
  integer k;
  integer m;
  wire apb_write;
  wire step_event;
  wire [1:0] step_target;
  wire step_dir;
  wire any_reset;
  wire unmapped;
  wire feedback_step;
  wire lock_disturb;
  assign pready = 1'b1;
  assign apb_write = psel && penable && pwrite;
  assign unmapped = (paddr[11:5] != 7'h00) || (paddr[1:0] != 2'h0);
  assign pslverr = psel && penable && unmapped;
  pdcs_sync2 #(.W(8)) u_sync_ctrl
  (
    .pclk(pclk),
    .presetn(presetn),
    .din({output_phase_target_select, phase_shift_direction, phase_increment_toggle, reference_source_switch,
      loop_reset, loop_full_clear_with_feedback_divider, embedded_function_wrapper}),
    .dout({s_sel, s_dir, s_tog, s_ref, s_rst, s_mrst, s_wrap})
  );
  pdcs_sync2 #(.W(93)) u_sync_clk
  (
    .pclk(pclk),
    .presetn(presetn),
    .din({reference_clock_present, secondary_pin_input, secondary_routing_input, primary_mux_input}),
    .dout({s_refok, s_pin, s_rout, s_pri})
  );
  // Settings port only exists when the wrapper is present; strobe gated otherwise
  pdcs_settings_regs u_settings
  (
    .pclk(pclk),
    .presetn(presetn),
    .settings_bus_strobe(settings_bus_strobe && s_wrap), // RULE7
    .settings_bus_write_enable(settings_bus_write_enable),
    .settings_bus_index(settings_bus_index),
    .settings_bus_write_data(settings_bus_write_data),
    .settings_bus_read_data(settings_bus_read_data),
    .settings_bus_acknowledge(settings_bus_acknowledge),
    .settings_changed(settings_changed),
    .divider_value(div_value),
    .feedback_divider(fb_value)
  );
  function [7:0] pdcs_step;
    input [7:0] value;
    input dir;
    begin
      pdcs_step = dir ? value - 8'h01 : value + 8'h01;
    end
  endfunction
  // Select 0 takes the clock pin, 1 to 7 the routing inputs
  function pdcs_sec_pick;
    input pin;
    input [6:0] routes;
    input [2:0] sel;
    begin
      pdcs_sec_pick = (sel == 3'h0) ? pin : routes[sel - 3'h1];
    end
  endfunction
  // Selects beyond the populated inputs read low instead of an unknown
  function pdcs_pri_pick;
    input [26:0] src;
    input [4:0] sel;
    input [4:0] count;
    begin
      pdcs_pri_pick = (sel < count) ? src[sel] : 1'b0;
    end
  endfunction
  // Origin bit chooses whether the ports or the register fields steer phase
  assign step_event = phase_ctrl[`PDCS_PC_ORIGIN_BIT] ?
    (phase_ctrl[`PDCS_PC_TOGGLE_BIT] != bus_tog_prev) : (s_tog != tog_prev); // RULE3
  assign step_target = phase_ctrl[`PDCS_PC_ORIGIN_BIT] ? phase_ctrl[1:0] : s_sel; // RULE1
  assign step_dir = phase_ctrl[`PDCS_PC_ORIGIN_BIT] ? phase_ctrl[`PDCS_PC_DIR_BIT] : s_dir; // RULE2
  assign any_reset = s_rst || s_mrst || reg_reset || reg_full_reset;
  // Any of these may knock the loop out of lock; each restarts the full wait
  assign feedback_step = step_event && (step_target == fb_output); // RULE5
  assign lock_disturb = any_reset || !s_refok[active_reference] || feedback_step
    || settings_changed; // RULE8 RULE12
  // Read-only words ignore writes; only unmapped offsets raise an error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_ctrl <= `PDCS_PC_RESET;
      sec_sel <= `PDCS_SEC_RESET;
      pri_sel <= `PDCS_PRI_RESET;
      ref_sel <= 1'b0;
      reg_reset <= 1'b0;
      reg_full_reset <= 1'b0;
    end
    else if (apb_write && !unmapped)
    begin
      case (paddr)
        `PDCS_ADDR_PHASE_CTRL: phase_ctrl <= pwdata;
        `PDCS_ADDR_REF_CTRL:
        begin
          ref_sel <= pwdata[`PDCS_RC_SEL_BIT];
          reg_reset <= pwdata[`PDCS_RC_RESET_BIT];
          reg_full_reset <= pwdata[`PDCS_RC_FULLRESET_BIT];
        end
        `PDCS_ADDR_SEC_SEL: sec_sel <= pwdata;
        `PDCS_ADDR_PRI_SEL: pri_sel <= pwdata;
        default: ;
      endcase
    end
  end
  // Phase offsets reload their configured value on any loop reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (k = 0; k < 4; k = k + 1)
        phase_offset[k] <= `PDCS_PHASE_RESET; // RULE4
      tog_prev <= 1'b0;
      bus_tog_prev <= 1'b0;
      fb_output <= 2'b00;
      feedback_divider_out <= `PDCS_FB_RESET;
      phase_control_origin <= 1'b0;
      active_reference <= 1'b0;
    end
    else
    begin
      tog_prev <= s_tog;
      bus_tog_prev <= phase_ctrl[`PDCS_PC_TOGGLE_BIT];
      fb_output <= phase_ctrl[6:5];
      phase_control_origin <= phase_ctrl[`PDCS_PC_ORIGIN_BIT]; // RULE13
      active_reference <= ref_sel ^ s_ref; // RULE6
      if (s_mrst || reg_full_reset)
        feedback_divider_out <= `PDCS_FB_RESET; // RULE12
      else if (!any_reset)
        feedback_divider_out <= fb_value;
      if (any_reset)
      begin
        for (k = 0; k < 4; k = k + 1)
          phase_offset[k] <= `PDCS_PHASE_RESET;
      end
      else if (step_event)
        phase_offset[step_target] <= pdcs_step(phase_offset[step_target], step_dir); // RULE1 RULE2 RULE3
    end
  end
  // Lock tracker: any disturbance restarts the full relock wait
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_LOCKING;
      lock_count <= 32'h00000000;
      loop_lock <= 1'b0;
    end
    else
    begin
      if (lock_disturb)
      begin
        state <= ST_LOCKING; // RULE8
        lock_count <= 32'h00000000;
        loop_lock <= 1'b0;
      end
      else
      begin
        case (state)
          ST_LOCKING:
          begin
            if (lock_count >= LOCK_CYCLES - 1)
            begin
              state <= ST_LOCKED;
              loop_lock <= 1'b1; // RULE11
            end
            else
              lock_count <= lock_count + 32'h00000001;
          end
          ST_LOCKED: loop_lock <= 1'b1;
          default: state <= ST_LOCKING;
        endcase
      end
    end
  end
  // Clock steering muxes: registered copies of the selected sampled inputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secondary_net <= 8'h00;
      primary_net <= 1'b0;
      phase_offset_out <= 8'h00;
    end
    else
    begin
      for (m = 0; m < 8; m = m + 1)
        secondary_net[m] <= pdcs_sec_pick(s_pin[m], s_rout[m*7 +: 7], sec_sel[m*3 +: 3]); // RULE9
      if (LARGE_VARIANT != 0)
        primary_net <= pdcs_pri_pick(s_pri, pri_sel[4:0], 5'h1B); // RULE10
      else
        primary_net <= pdcs_pri_pick(s_pri, pri_sel[4:0], 5'h11); // RULE10
      // Follows whichever output the step controls currently target
      phase_offset_out <= phase_offset[step_target];
    end
  end
  always @*
  begin
    prdata = 32'h00000000;
    if (psel && !pwrite)
    begin
      case (paddr)
        `PDCS_ADDR_PHASE_CTRL: prdata = phase_ctrl;
        `PDCS_ADDR_REF_CTRL: prdata = {29'h0, reg_full_reset, reg_reset, ref_sel};
        `PDCS_ADDR_STATUS: prdata = {28'h0, s_mrst, active_reference, phase_control_origin, loop_lock};
        `PDCS_ADDR_SEC_SEL: prdata = sec_sel;
        `PDCS_ADDR_PRI_SEL: prdata = pri_sel;
        `PDCS_ADDR_PHASE_READ: prdata = {phase_offset[3], phase_offset[2], phase_offset[1], phase_offset[0]};
        `PDCS_ADDR_SET_DIV: prdata = {24'h0, div_value};
        `PDCS_ADDR_SET_FB: prdata = {24'h0, feedback_divider_out};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule // pdcs_top

// [tb/pdcs_sva.sv]
module pdcs_sva
#(
  parameter LOCK_CYCLES = 12500
)
(
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire embedded_function_wrapper,
  input wire settings_bus_strobe,
  input wire settings_bus_write_enable,
  input wire settings_bus_acknowledge,
  input wire loop_reset,
  input wire loop_full_clear_with_feedback_divider,
  input wire loop_lock,
  input wire [7:0] feedback_divider_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Lock-low run length, so a relock can be held to the full wait
  reg [31:0] low_cnt;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      low_cnt <= 32'h0;
    else
      low_cnt <= loop_lock ? 32'h0 : low_cnt + 32'h1;
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access stalled");
  a_unmapped_err: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
    else $error("no slave error");
  a_mapped_ok: assert property (psel && penable && paddr < 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("bad slave error");
  a_ack_single: assert property (settings_bus_acknowledge |=> !settings_bus_acknowledge)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(settings_bus_acknowledge) |-> $past(settings_bus_strobe))
    else $error("ack without strobe");
  a_no_wrapper: assert property (!embedded_function_wrapper [*4] |-> !settings_bus_acknowledge)
    else $error("ack without wrapper");
  a_write_unlock: assert property (settings_bus_acknowledge && settings_bus_write_enable |-> ##[0:3] !loop_lock)
    else $error("lock kept after write");
  a_relock_wait: assert property ($rose(loop_lock) |-> low_cnt >= LOCK_CYCLES - 1)
    else $error("relock too early");
  a_reset_unlock: assert property (loop_reset [*5] |-> !loop_lock)
    else $error("lock during reset");
  a_full_clear: assert property (loop_full_clear_with_feedback_divider [*6] |-> feedback_divider_out == 8'h01)
    else $error("divider not cleared");
  c_relock: cover property ($rose(loop_lock));
  c_write_ack: cover property (settings_bus_acknowledge && settings_bus_write_enable);
  c_slverr: cover property (pslverr);
endmodule // pdcs_sva

// [tb/pdcs_top_tb_top.sv]
module pdcs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg reference_source_switch = 1'b0, loop_reset = 1'b0, loop_full_clear_with_feedback_divider = 1'b0;
  reg embedded_function_wrapper = 1'b1, ok, err;
  reg [7:0] secondary_pin_input = 8'h00, sd;
  reg [55:0] secondary_routing_input = 56'h0;
  reg [26:0] primary_mux_input = 27'h0;
  reg [1:0] reference_clock_present = 2'h3;
  wire [31:0] prdata;
  wire pready, pslverr, settings_bus_strobe, settings_bus_write_enable, settings_bus_acknowledge;
  wire primary_net, loop_lock, phase_shift_direction, phase_increment_toggle, phase_control_origin, active_reference;
  wire [1:0] output_phase_target_select;
  wire [4:0] settings_bus_index;
  wire [7:0] settings_bus_write_data, settings_bus_read_data, secondary_net, phase_offset_out, feedback_divider_out;
  integer num_errors = 0, checks = 0, cyc = 0, i;
  logic [11:0] ra [0:5] = '{12'h000, 12'h00C, 12'h010, 12'h018, 12'h01C, 12'h020};
  logic [31:0] re [0:5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0};
  always #2 pclk = ~pclk;
  pdcs_top #(.LOCK_CYCLES(20)) pdcs_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .output_phase_target_select, .phase_shift_direction, .phase_increment_toggle,
    .reference_source_switch, .loop_reset, .loop_full_clear_with_feedback_divider, .embedded_function_wrapper,
    .settings_bus_strobe, .settings_bus_write_enable, .settings_bus_index, .settings_bus_write_data,
    .settings_bus_read_data, .settings_bus_acknowledge, .reference_clock_present, .secondary_pin_input,
    .secondary_routing_input, .primary_mux_input, .secondary_net, .primary_net, .phase_offset_out, .loop_lock,
    .phase_control_origin, .active_reference, .feedback_divider_out);
  pdcs_user_model pdcs_user_model_i (.pclk, .output_phase_target_select, .phase_shift_direction,
    .phase_increment_toggle, .settings_bus_strobe, .settings_bus_write_enable, .settings_bus_index,
    .settings_bus_write_data, .settings_bus_read_data, .settings_bus_acknowledge);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
        @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wait_lock;
    begin
      i = 0;
      while (loop_lock !== 1'b1 && i < 200)
      begin
        @(posedge pclk);
        i = i + 1;
      end
      chk(loop_lock, 1'b1);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(feedback_divider_out, 8'h01);
    for (i = 0; i < 6; i = i + 1)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, re[i]);
    end
    chk(err, 1'b1);
    wait_lock;
    pdcs_user_model_i.step(2'h1, 1'b0);
    pdcs_user_model_i.step(2'h1, 1'b0);
    pdcs_user_model_i.step(2'h1, 1'b0);
    pdcs_user_model_i.step(2'h1, 1'b1);
    chk(phase_offset_out, 8'h02);
    chk(loop_lock, 1'b1);
    pdcs_user_model_i.step(2'h0, 1'b0);
    chk(loop_lock, 1'b0);
    wait_lock;
    pdcs_user_model_i.xfer(1'b1, 5'h01, 8'h05, 0, sd, ok);
    chk(ok, 1'b1);
    @(posedge pclk);
    chk(loop_lock, 1'b0);
    chk(feedback_divider_out, 8'h05);
    pdcs_user_model_i.xfer(1'b0, 5'h01, 8'h00, 3, sd, ok);
    chk(sd, 8'h05);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h5);
    wait_lock;
    embedded_function_wrapper <= 1'b0;
    pdcs_user_model_i.xfer(1'b1, 5'h00, 8'h07, 4, sd, ok);
    chk(ok, 1'b0);
    embedded_function_wrapper <= 1'b1;
    loop_full_clear_with_feedback_divider <= 1'b1;
    loop_reset <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(feedback_divider_out, 8'h01);
    chk(loop_lock, 1'b0);
    loop_full_clear_with_feedback_divider <= 1'b0;
    loop_reset <= 1'b0;
    wait_lock;
    reference_source_switch <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(active_reference, 1'b1);
    reference_clock_present <= 2'h1;
    repeat (8) @(posedge pclk);
    chk(loop_lock, 1'b0);
    reference_clock_present <= 2'h3;
    secondary_pin_input <= 8'h02;
    secondary_routing_input <= 56'h4;
    primary_mux_input <= 27'h20;
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h010, 32'h5);
    apb(1'b1, 12'h000, 32'h10);
    repeat (8) @(posedge pclk);
    chk(secondary_net, 8'h03);
    chk(primary_net, 1'b1);
    chk(phase_control_origin, 1'b1);
    apb(1'b1, 12'h000, 32'h19);
    repeat (3) @(posedge pclk);
    chk(phase_offset_out, 8'h01);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h100);
    tally_and_finish;
  end
endmodule // pdcs_top_tb_top
bind pdcs_top pdcs_sva #(.LOCK_CYCLES(LOCK_CYCLES)) pdcs_sva_i (.pclk, .presetn, .paddr, .psel, .penable, .pready,
  .pslverr, .embedded_function_wrapper, .settings_bus_strobe, .settings_bus_write_enable, .settings_bus_acknowledge,
  .loop_reset, .loop_full_clear_with_feedback_divider, .loop_lock, .feedback_divider_out);

// [tb/pdcs_user_model.sv]
module pdcs_user_model
(
  input wire pclk,
  output reg [1:0] output_phase_target_select,
  output reg phase_shift_direction,
  output reg phase_increment_toggle,
  output reg settings_bus_strobe,
  output reg settings_bus_write_enable,
  output reg [4:0] settings_bus_index,
  output reg [7:0] settings_bus_write_data,
  input wire [7:0] settings_bus_read_data,
  input wire settings_bus_acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    output_phase_target_select = 2'h0;
    phase_shift_direction = 1'b0;
    phase_increment_toggle = 1'b0;
    settings_bus_strobe = 1'b0;
    settings_bus_write_enable = 1'b0;
    settings_bus_index = 5'h00;
    settings_bus_write_data = 8'h00;
  end
  // Target and direction settle through the synchroniser before the edge
  task step(input [1:0] tgt, input dir);
    begin
      @(posedge pclk);
      output_phase_target_select <= tgt;
      phase_shift_direction <= dir;
      repeat (3) @(posedge pclk);
      phase_increment_toggle <= ~phase_increment_toggle;
      repeat (8) @(posedge pclk);
    end
  endtask
  // Strobe held until ack; gives up after a bound when no ack comes
  task xfer(input we, input [4:0] idx, input [7:0] wd, input integer slow, output [7:0] rdat, output ok);
    integer n;
    begin
      repeat (slow + 1) @(posedge pclk);
      settings_bus_strobe <= 1'b1;
      settings_bus_write_enable <= we;
      settings_bus_index <= idx;
      settings_bus_write_data <= wd;
      ok = 1'b0;
      n = 0;
      while (!ok && n < 12)
      begin
        @(posedge pclk);
        ok = settings_bus_acknowledge;
        n = n + 1;
      end
      rdat = settings_bus_read_data;
      settings_bus_strobe <= 1'b0;
      settings_bus_write_data <= ~wd;
      settings_bus_index <= ~idx;
    end
  endtask
endmodule // pdcs_user_model
